// ---- hw/adc_if_pkg.sv ----
package adc_if_pkg;

  // Receiver state of the two-wire slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_SKIP
  } link_state_t;

  // Own seven-bit bus address; the value is arbitrary.
  localparam logic [6:0] OWN_ADDRESS     = 7'h2a;

  // Byte framing on the serial line and pin synchroniser depth.
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] ACK_BIT         = 4'h9;
  localparam int         SYNC_STAGES     = 3;

  // High-speed master code: upper five bits fixed, low three bits ignored.
  localparam logic [4:0] HS_CODE_TOP     = 5'h01;

  // Common field positions of both written bytes.
  localparam int         POS_REG_SELECT  = 7;

  // Setup byte field positions.
  localparam int         POS_REF_HI      = 6;
  localparam int         POS_REF_LO      = 4;
  localparam int         POS_CLOCK_SRC   = 3;
  localparam int         POS_POLARITY    = 2;
  localparam int         POS_CFG_RESET   = 1;

  // Configuration byte field positions.
  localparam int         POS_SCAN_HI     = 6;
  localparam int         POS_SCAN_LO     = 5;
  localparam int         POS_CHAN_HI     = 4;
  localparam int         POS_CHAN_LO     = 1;
  localparam int         POS_INPUT_MODE  = 0;

  // Power-up values of the setup byte fields.
  localparam logic [2:0] RST_REF_SELECT  = 3'h0;
  localparam logic       RST_EXT_CLOCK   = 1'h0;
  localparam logic       RST_POLARITY    = 1'h0;

  // Power-up values of the configuration byte fields.
  localparam logic [1:0] RST_SCAN        = 2'h0;
  localparam logic [3:0] RST_CHANNEL     = 4'h0;
  localparam logic       RST_INPUT_MODE  = 1'h1;

  // Result coding limits in converter LSBs.
  localparam logic signed [12:0] BIP_MAX = 13'sh07ff;
  localparam logic signed [12:0] BIP_MIN = -13'sh0800;

endpackage

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps

// Three-stage synchroniser for pin inputs. The filtered level only moves
// when the second and third stages agree, which also rejects single-cycle
// glitches on the slow bus lines.
module pin_sync #(
  parameter int          WIDTH = 2,
  parameter logic [1:0]  IDLE  = 2'h3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;  // Metastable stage, read by stage2 only.
  logic [WIDTH-1:0] stage2;  // Second stage.
  logic [WIDTH-1:0] stage3;  // Third stage.
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);  // Stages agree per bit.

  // Idle bus lines float high, so the stages reset to the idle level.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= IDLE[WIDTH-1:0];
      stage2 <= IDLE[WIDTH-1:0];
      stage3 <= IDLE[WIDTH-1:0];
      level  <= IDLE[WIDTH-1:0];
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (agree & stage3) | (~agree & level);
    end
  end

endmodule

// ---- hw/result_coder.sv ----
`timescale 1ns/1ps

// Maps a signed difference sample, in LSBs of the full reference span, to
// the twelve-bit output code.
module result_coder (
  input  wire logic               polarity,
  input  wire logic               input_mode,
  input  wire logic signed [12:0] sample,
  output logic             [11:0] code
);

  // Single-ended inputs ignore the polarity select entirely.
  wire bipolar  = polarity & ~input_mode;
  // Bipolar span is half the reference each way, so clamp to that range.
  wire bip_hi   = sample > adc_if_pkg::BIP_MAX;
  wire bip_lo   = sample < adc_if_pkg::BIP_MIN;
  wire [11:0] bip_code = bip_hi ? adc_if_pkg::BIP_MAX[11:0]
                       : bip_lo ? adc_if_pkg::BIP_MIN[11:0] : sample[11:0];
  // Unipolar spans zero to the reference; negative inputs give code zero.
  wire [11:0] uni_code = sample[12] ? 12'h000 : sample[11:0];

  // Straight binary when unipolar, two's complement when bipolar.
  assign code = bipolar ? bip_code : uni_code;

endmodule

// ---- hw/adc_serial_slave.sv ----
// Operation
// - Unipolar: negative differential input gives zero.
// - Unipolar straight binary, bipolar two's complement.
// - Single-ended always unipolar, polarity ignored.
// - One bit per clock; data stable high.
// - Data fall: START; data rise: STOP.
// - Repeated START keeps transaction and speed mode.
// - Acknowledge drives data low through ninth clock.
// - Idle waits for START plus own address.
// - Address LSB: zero write, one read.
// - Acknowledge own address for one clock.
// - Power-up in fast/standard timing mode.
// - High-speed master code: not-acknowledge, then HS.
// - STOP in high-speed returns to fast/standard.
// - Written byte MSB picks setup or configuration.
// - One or two bytes, each acknowledged.
// - Setup reset bit zero restores configuration defaults.
// - Setup byte LSB is ignored.
// - Configuration powers up scan 0, channel 0, single.
// - Input mode one: to ground; zero: pair.
// - Internal clock mode stretches clock during conversion.
`timescale 1ns/1ps

module adc_serial_slave #(
  parameter logic [6:0] SLAVE_ADDRESS = adc_if_pkg::OWN_ADDRESS
) (
  input  wire logic               MCLK,
  input  wire logic               RSTN,
  input  wire logic               SCL_I,
  input  wire logic               SDA_I,
  output logic                    SDA_O,
  output logic                    SDA_OE,
  output logic                    SCL_O,
  output logic                    SCL_OE,
  input  wire logic               CONV_BUSY,
  input  wire logic signed [12:0] SAMPLE,
  output logic             [11:0] RESULT,
  output logic                    CONV_START,
  output logic                    HS_MODE,
  output logic             [2:0]  REF_SELECT,
  output logic                    EXT_CLOCK,
  output logic                    POLARITY,
  output logic             [1:0]  SCAN_SELECT,
  output logic             [3:0]  CHANNEL_SELECT,
  output logic                    INPUT_MODE
);

  // Filtered bus levels and their previous values for edge finding.
  logic [1:0] bus_level;     // Bit 1 is the clock line, bit 0 the data line.
  logic       scl_prev;      // Clock level one cycle ago.
  logic       sda_prev;      // Data level one cycle ago.

  // Transfer state.
  adc_if_pkg::link_state_t state;  // Receiver phase.
  logic [3:0] bit_cnt;       // Clock rises seen in the current byte.
  logic [7:0] shift;         // Incoming byte, MSB first.
  logic       hs_arm;        // Master code seen; switch after its ninth clock.
  logic       stretch;       // Holding the clock low for a conversion.

  // Coded result from the output formatter.
  logic [11:0] coded;

  // Both pins are sampled on the system clock; the bus is far slower.
  pin_sync #(
    .WIDTH (2),
    .IDLE  (2'h3)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .raw   ({SCL_I, SDA_I}),
    .level (bus_level)
  );

  // Output coding of the converter sample.
  result_coder u_coder (
    .polarity   (POLARITY),
    .input_mode (INPUT_MODE),
    .sample     (SAMPLE),
    .code       (coded)
  );

  // Edge and bus condition decode from the filtered levels.
  wire scl       = bus_level[1];
  wire sda       = bus_level[0];
  wire scl_rise  = scl & ~scl_prev;
  wire scl_fall  = ~scl & scl_prev;
  // Data may only move while the clock is high to mark a condition.
  wire start_seen = scl & scl_prev & sda_prev & ~sda;
  wire stop_seen  = scl & scl_prev & ~sda_prev & sda;

  // Byte boundary decode: eighth falling edge ends the data bits, the
  // ninth falling edge ends the acknowledge slot.
  wire byte_done = scl_fall & (bit_cnt == adc_if_pkg::BYTE_BITS);
  wire ack_done  = scl_fall & (bit_cnt == adc_if_pkg::ACK_BIT);

  // Address decode on the received byte.
  wire addr_match = shift[7:1] == SLAVE_ADDRESS;
  wire rw_read    = shift[0];
  // Only the top five bits identify the master code.
  wire hs_code    = shift[7:3] == adc_if_pkg::HS_CODE_TOP;

  // Written byte sorting.
  wire is_setup   = shift[adc_if_pkg::POS_REG_SELECT];
  wire wr_done    = byte_done & (state == adc_if_pkg::ST_WRITE);
  wire setup_wr   = wr_done & is_setup;
  wire config_wr  = wr_done & ~is_setup;
  // Reset bit low restores the configuration byte; a one does nothing.
  wire cfg_reset  = setup_wr & ~shift[adc_if_pkg::POS_CFG_RESET];

  // Address acknowledge is given for our address only; the master code
  // is deliberately left unanswered so the line stays high.
  wire addr_done  = byte_done & (state == adc_if_pkg::ST_ADDR);
  wire addr_ack   = addr_done & addr_match;
  wire addr_hs    = addr_done & ~addr_match & hs_code;
  wire give_ack   = addr_ack | wr_done;

  // A read starts a conversion after the ack; in internal clock mode it also stretches.
  wire read_go    = ack_done & ~hs_arm & (state == adc_if_pkg::ST_ADDR)
                    & rw_read;
  wire stretch_go = read_go & ~EXT_CLOCK;

  // Remember the line levels for edge finding.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  // Bit counter and shifter. Data is taken on the rising clock edge,
  // where it is guaranteed stable, one bit per clock.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else if (start_seen || stop_seen || ack_done) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && bit_cnt < adc_if_pkg::ACK_BIT) begin
      // Only the first eight bits shift; the ninth is the ack slot.
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt < adc_if_pkg::BYTE_BITS) begin
        shift <= {shift[6:0], sda};
      end
    end
  end

  // Transfer state machine. START and repeated START both restart the
  // address phase; STOP always drops back to idle.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      state <= adc_if_pkg::ST_IDLE;
    end else if (stop_seen) begin
      state <= adc_if_pkg::ST_IDLE;
    end else if (start_seen) begin
      state <= adc_if_pkg::ST_ADDR;
    end else if (addr_done && !addr_match && !hs_code) begin
      // Someone else's address: sit out until the next condition.
      state <= adc_if_pkg::ST_SKIP;
    end else if (ack_done && state == adc_if_pkg::ST_ADDR) begin
      // After the master code the master must send a repeated START.
      unique case ({hs_arm, rw_read})
        2'b00:   state <= adc_if_pkg::ST_WRITE;
        2'b01:   state <= adc_if_pkg::ST_READ;
        default: state <= adc_if_pkg::ST_SKIP;
      endcase
    end
  end

  // Speed mode. Power-up and any STOP give fast/standard timing; a
  // repeated START leaves the mode as it is.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      HS_MODE <= 1'h0;
      hs_arm  <= 1'h0;
    end else if (stop_seen) begin
      HS_MODE <= 1'h0;
      hs_arm  <= 1'h0;
    end else if (addr_hs) begin
      hs_arm  <= 1'h1;
    end else if (ack_done && hs_arm) begin
      // The switch happens only once the not-acknowledge slot is over.
      HS_MODE <= 1'h1;
      hs_arm  <= 1'h0;
    end
  end

  // Data line drive. The ack is set up on the falling edge before the
  // ninth clock and released on its falling edge, so it covers the whole
  // high phase. A condition on the bus releases the line at once.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      SDA_OE <= 1'h0;
      SDA_O  <= 1'h0;
    end else if (start_seen || stop_seen || ack_done) begin
      SDA_OE <= 1'h0;
    end else if (give_ack) begin
      SDA_OE <= 1'h1;
    end
  end

  // Clock stretching. The conversion request is a one-cycle pulse; the
  // clock is held low until the converter reports idle again. The pulse
  // itself keeps the hold up for the cycle before busy can rise.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      stretch    <= 1'h0;
      CONV_START <= 1'h0;
      SCL_OE     <= 1'h0;
      SCL_O      <= 1'h0;
    end else begin
      CONV_START <= read_go;
      if (stretch_go) begin
        stretch <= 1'h1;
      end else if (!CONV_BUSY && !CONV_START) begin
        stretch <= 1'h0;
      end
      SCL_OE <= stretch_go | (stretch & (CONV_BUSY | CONV_START));
    end
  end

  // Setup byte. Bit 0 is don't-care and is never stored.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      REF_SELECT <= adc_if_pkg::RST_REF_SELECT;
      EXT_CLOCK  <= adc_if_pkg::RST_EXT_CLOCK;
      POLARITY   <= adc_if_pkg::RST_POLARITY;
    end else if (setup_wr) begin
      REF_SELECT <= shift[adc_if_pkg::POS_REF_HI:adc_if_pkg::POS_REF_LO];
      EXT_CLOCK  <= shift[adc_if_pkg::POS_CLOCK_SRC];
      POLARITY   <= shift[adc_if_pkg::POS_POLARITY];
    end
  end

  // Configuration byte, including the restore from the setup byte.
  // Input mode one measures to ground, zero measures the channel pair.
  always_ff @(posedge MCLK) begin
    if (!RSTN || cfg_reset) begin
      SCAN_SELECT    <= adc_if_pkg::RST_SCAN;
      CHANNEL_SELECT <= adc_if_pkg::RST_CHANNEL;
      INPUT_MODE     <= adc_if_pkg::RST_INPUT_MODE;
    end else if (config_wr) begin
      SCAN_SELECT    <= shift[adc_if_pkg::POS_SCAN_HI:adc_if_pkg::POS_SCAN_LO];
      CHANNEL_SELECT <= shift[adc_if_pkg::POS_CHAN_HI:adc_if_pkg::POS_CHAN_LO];
      INPUT_MODE     <= shift[adc_if_pkg::POS_INPUT_MODE];
    end
  end

  // Registered output code, so the port comes straight from a flop.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      RESULT <= 12'h000;
    end else begin
      RESULT <= coded;
    end
  end

  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  ack_on_match_a: assert property (addr_ack |=> SDA_OE ##1 SDA_OE[*1])
    else $error("Own address was not acknowledged.");
  ack_release_a: assert property (ack_done |=> !SDA_OE)
    else $error("Acknowledge held past the ninth clock.");
  // Any bus condition must free the data line so the master can drive it.
  cond_release_a: assert property (start_seen || stop_seen |=> !SDA_OE)
    else $error("Data line still held after a bus condition.");
  // A foreign address must leave the data line alone for the whole transfer.
  skip_quiet_a: assert property (state == adc_if_pkg::ST_SKIP |-> !SDA_OE)
    else $error("Data line driven for a foreign address.");
  hs_nack_a: assert property (addr_hs |=> !SDA_OE && hs_arm)
    else $error("Master code was acknowledged.");
  hs_switch_a: assert property (ack_done && hs_arm && !stop_seen |=> HS_MODE)
    else $error("High-speed mode not entered after master code.");
  stop_mode_a: assert property (stop_seen |=>
                                !HS_MODE && state == adc_if_pkg::ST_IDLE)
    else $error("STOP did not return to fast mode.");
  rstart_mode_a: assert property (start_seen |=> HS_MODE == $past(HS_MODE)
                                  && state == adc_if_pkg::ST_ADDR)
    else $error("Repeated START changed the speed mode.");
  setup_route_a: assert property (setup_wr |=> REF_SELECT == $past(shift[6:4])
                                  && POLARITY == $past(shift[2]))
    else $error("Setup byte not stored.");
  cfg_restore_a: assert property (cfg_reset |=> INPUT_MODE
                                  && CHANNEL_SELECT == 4'h0 && SCAN_SELECT == 2'h0)
    else $error("Configuration not restored by setup reset bit.");
  single_unipolar_a: assert property (INPUT_MODE && SAMPLE < 0 && !cfg_reset
                                      && !config_wr |=> RESULT == 12'h000)
    else $error("Single-ended negative input gave a non-zero code.");
  stretch_hold_a: assert property (stretch_go |=> SCL_OE ##1 (SCL_OE || !stretch))
    else $error("Clock not held low for the conversion.");

  write_cover_c: cover property (setup_wr ##[1:400] config_wr);
  hs_cover_c: cover property (addr_hs ##[1:400] HS_MODE ##[1:400] addr_ack);
  read_cover_c: cover property (stretch_go ##[1:400] !SCL_OE);
  skip_cover_c: cover property (addr_done && !addr_match && !hs_code);
  single_cover_c: cover property (INPUT_MODE && POLARITY && SAMPLE < 0);

endmodule

// ---- tb/bus_master_model.sv ----
`timescale 1ns/1ps

// Behavioural two-wire bus master with open-drain drives and a 125 ns clock.
module bus_master_model (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // The data line moves mid-low so both lines cross the slave's filter in order.
  localparam realtime T_SET  = 37.0;
  localparam realtime T_LOW  = 38.0;
  localparam realtime T_HIGH = 50.0;

  // Both lines are released at time zero, so the bus starts idle.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Releases the clock and waits for the wire, so a stretching slave is honoured.
  task automatic clock_up();
    #(T_LOW);
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #(T_HIGH / 2.0);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic bus_start();
    #(T_SET);
    sda_low = 1'b0;
    clock_up();
    sda_low = 1'b1;
    #(T_HIGH / 2.0);
    scl_low = 1'b1;
  endtask

  // Stop: data rises while the clock is high, ending the transfer.
  task automatic bus_stop();
    #(T_SET);
    sda_low = 1'b1;
    clock_up();
    sda_low = 1'b0;
    #(T_HIGH);
  endtask

  // One bit per clock; data only changes while the clock is low.
  task automatic bit_cycle(input logic tx, output logic rx);
    #(T_SET);
    sda_low = ~tx;
    clock_up();
    rx = sda_line;
    #(T_HIGH / 2.0);
    scl_low = 1'b1;
  endtask

  // A byte MSB first, then the ninth clock; a released line there reads as no acknowledge.
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(tx[i], rx[i]);
    end
    bit_cycle(ack_in, ack_out);
  endtask
endmodule

// ---- tb/tb_adc_serial_slave.sv ----
`timescale 1ns/1ps

module tb_adc_serial_slave;
  localparam logic [7:0] WR_ADDR = {adc_if_pkg::OWN_ADDRESS, 1'b0};
  localparam logic [7:0] RD_ADDR = {adc_if_pkg::OWN_ADDRESS, 1'b1};

  logic                    MCLK;
  logic                    RSTN;
  logic signed [12:0]      SAMPLE;
  logic                    SDA_O, SDA_OE, SCL_O, SCL_OE, CONV_START, HS_MODE;
  logic                    EXT_CLOCK, POLARITY, INPUT_MODE;
  logic        [11:0]      RESULT;
  logic        [2:0]       REF_SELECT;
  logic        [1:0]       SCAN_SELECT;
  logic        [3:0]       CHANNEL_SELECT;
  logic                    scl_low, sda_low, scl_line, sda_line;
  logic                    CONV_BUSY;          // Fake converter busy level.
  logic        [5:0]       busy_left = 6'h00;  // Remaining cycles of a fake conversion.
  int                      stretch_len = 0;    // Cycles with the clock held by the slave.
  int                      tick = 0;
  int                      error_cnt = 0;
  int                      checks = 0;
  logic                    a;
  logic        [7:0]       rx;
  int                      s0;

  // Pull-ups win unless some party pulls the wire low.
  assign scl_line  = ~(scl_low | SCL_OE);
  assign sda_line  = ~(sda_low | SDA_OE);
  assign CONV_BUSY = (busy_left != 6'h00);

  adc_serial_slave u_adc_serial_slave (.MCLK(MCLK), .RSTN(RSTN), .SCL_I(scl_line),
    .SDA_I(sda_line), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .CONV_BUSY(CONV_BUSY), .SAMPLE(SAMPLE), .RESULT(RESULT), .CONV_START(CONV_START),
    .HS_MODE(HS_MODE), .REF_SELECT(REF_SELECT), .EXT_CLOCK(EXT_CLOCK), .POLARITY(POLARITY),
    .SCAN_SELECT(SCAN_SELECT), .CHANNEL_SELECT(CHANNEL_SELECT), .INPUT_MODE(INPUT_MODE));

  bus_master_model u_bus_master_model (.scl_line(scl_line), .sda_line(sda_line),
    .scl_low(scl_low), .sda_low(sda_low));

  // Free-running system clock.
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Fake converter busy for 40 cycles after each start pulse; also the run ceiling.
  always @(posedge MCLK) begin
    if (CONV_START) begin
      busy_left <= 6'd40;
    end else if (busy_left != 6'h00) begin
      busy_left <= busy_left - 6'h01;
    end
    if (SCL_OE) begin
      stretch_len <= stretch_len + 1;
    end
    tick <= tick + 1;
    if (tick == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Lets the slave's registered outputs settle before they are looked at.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // Master writes one byte and hands back the acknowledge bit (0 = acknowledged).
  task automatic send(input logic [7:0] tx, output logic ack);
    u_bus_master_model.xfer(tx, 1'b1, rx, ack);
  endtask

  // Applies a sample and compares the coded result a few cycles later.
  task automatic res(input logic signed [12:0] s, input logic [11:0] e);
    SAMPLE = s;
    wait_clk(3);
    cmp(RESULT, e);
  endtask

  task automatic cmp_setup(input logic [4:0] e);
    cmp({REF_SELECT, EXT_CLOCK, POLARITY}, e);
  endtask

  task automatic cmp_cfg(input logic [6:0] e);
    cmp({SCAN_SELECT, CHANNEL_SELECT, INPUT_MODE}, e);
  endtask

  initial begin
    RSTN   = 1'b0;
    SAMPLE = 13'sh0000;
    wait_clk(12);
    RSTN = 1'b1;
    wait_clk(6);
    cmp_setup(5'h00);
    cmp_cfg(7'h01);
    cmp(HS_MODE, 1'b0);
    // Configuration then setup in one transfer; setup bit 0 set without effect.
    u_bus_master_model.bus_start();
    send(WR_ADDR, a);
    cmp(a, 1'b0);
    send(8'h5b, a);
    cmp(a, 1'b0);
    send(8'hff, a);
    cmp(a, 1'b0);
    u_bus_master_model.bus_stop();
    cmp_cfg(7'h5b);
    cmp_setup(5'h1f);
    // Setup alone with its reset bit low restores the configuration only.
    u_bus_master_model.bus_start();
    send(WR_ADDR, a);
    send(8'h8c, a);
    u_bus_master_model.bus_stop();
    cmp_cfg(7'h01);
    cmp_setup(5'h03);
    // A foreign address is not acknowledged and its data is not taken.
    u_bus_master_model.bus_start();
    send({adc_if_pkg::OWN_ADDRESS ^ 7'h01, 1'b0}, a);
    cmp(a, 1'b1);
    send(8'h5b, a);
    cmp(a, 1'b1);
    u_bus_master_model.bus_stop();
    cmp_cfg(7'h01);
    // Master code, repeated start, write in high speed, then stop.
    u_bus_master_model.bus_start();
    send(8'h0d, a);
    cmp(a, 1'b1);
    // The mode flips five system clocks after the pin edge, behind the filter.
    wait_clk(6);
    cmp(HS_MODE, 1'b1);
    u_bus_master_model.bus_start();
    send(WR_ADDR, a);
    cmp(a, 1'b0);
    send(8'h02, a);
    cmp(HS_MODE, 1'b1);
    u_bus_master_model.bus_stop();
    wait_clk(6);
    cmp(HS_MODE, 1'b0);
    // Differential, bipolar: two's complement with clamping.
    res(-13'sd5, 12'hffb);
    res(13'sd3000, 12'h7ff);
    res(-13'sd3000, 12'h800);
    // Differential, unipolar, internal clock.
    u_bus_master_model.bus_start();
    send(WR_ADDR, a);
    send(8'h82, a);
    u_bus_master_model.bus_stop();
    res(-13'sd5, 12'h000);
    res(13'sh0123, 12'h123);
    // Single-ended with bipolar requested still codes unipolar.
    u_bus_master_model.bus_start();
    send(WR_ADDR, a);
    send(8'h01, a);
    send(8'h86, a);
    u_bus_master_model.bus_stop();
    res(-13'sd5, 12'h000);
    res(13'sh0456, 12'h456);
    // Read in internal clock mode: the clock is held while the converter is busy.
    s0 = stretch_len;
    u_bus_master_model.bus_start();
    send(RD_ADDR, a);
    cmp(a, 1'b0);
    u_bus_master_model.xfer(8'hff, 1'b1, rx, a);
    u_bus_master_model.bus_stop();
    cmp((stretch_len - s0) inside {[40:43]}, 1'b1);
    // Both lines are released once the bus is idle again.
    cmp({SDA_O, SCL_O, SDA_OE, SCL_OE}, 4'h0);
    summarize();
  end
endmodule
